// file: hdl/gdfp_top.sv
// Purpose: fault detection and response for a three-phase gate driver
// Assumes: comparator flags are synchronous; fets ordered hs0,ls0,hs1..
// Notes:   register access over classic Wishbone, one ack per request
//
// Operation
// - rail undervoltage turns all fets off and pulls the error pin low
// - undervoltage latches summary and gate supply undervoltage flags
// - undervoltage recovers alone; its flag stays until a clear
// - serial variant can disable undervoltage; pin variant never can
// - drain-source trip on an enabled fet must outlast the filter time
// - pin variant: fixed 4 us filter, 8 ms retry, pin tie disables
// - serial variant: level, filter and four response modes by register
// - a new pwm rising edge clears a pending overcurrent unless disabled
// - linking 0 stops own half-bridge, linking 1 stops all three
// - latched mode stops fets, flags held until clear with condition gone
// - retry mode stops fets and resumes when the retry interval expires
// - report mode keeps driving, pin low until clear with condition gone or a new pwm rising edge
// - disabled mode takes no action on overcurrent
// - shunt trip must outlast the filter time, then follows the mode
// - pin variant shunt: fixed level, 4 us filter, 8 ms retry
// - shunt modes mirror drain-source; only retry sets per-phase flags
// - shunt off in mode 11b or with shunt disable; drain-source kept
// - a stuck gate stops all fets, pulls pin low, latches gate flags
// - gate fault recovers only after clear with the condition gone
// - serial variant gate fault disable turns detection off
`timescale 1ns/10ps
module gdfp_top
   import gdfp_pkg::*;
#(
   parameter int RETRY_CYCLES = RETRY_CYC
)(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // variant straps and enable reset
   input  wire logic        serial_variant_i,
   input  wire logic        vds_pin_disable_i,
   input  wire logic        enable_reset_i,
   // analog comparator flags
   input  wire logic        charge_pump_rail_uv_i,
   input  wire logic        low_side_gate_rail_uv_i,
   input  wire logic [5:0]  drain_source_over_i,
   input  wire logic [2:0]  shunt_sense_input_over_i,
   input  wire logic [5:0]  gate_stuck_i,
   // pwm in, gates out
   input  wire logic [5:0]  pwm_i,
   output logic      [5:0]  gate_drive_o,
   output logic      [3:0]  drain_source_trip_level_o,
   output logic      [1:0]  shunt_trip_level_o,
   output logic             error_indicator_pin_n_o
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0]             ctrl;
      logic                    uv_flag;
      logic                    vds_flag;
      logic                    sh_flag;
      logic                    gde_flag;
      logic [5:0]              vds_fet;
      logic [2:0]              sh_phase;
      logic [5:0]              gde_gate;
      logic [8:0][FILT_W-1:0]  filt_cnt;
      logic [5:0]              pwm_prev;
      logic [2:0]              oc_pend;
      logic                    rep_pend;
      logic                    gde_pend;
      logic                    retry_act;
      logic [RETRY_W-1:0]      retry_cnt;
      logic                    ack;
      logic [31:0]             dat;
      logic [5:0]              gate;
      logic                    pin_n;
      logic [1:0]              slvl;
   } gdfp_state_t;

   gdfp_state_t r;
   gdfp_state_t n;

   // filter length for a select code
   function automatic logic [FILT_W-1:0] filt_len(input logic [1:0] sel);
      case (sel)
         2'h0:    filt_len = FILT_W'(FILT_1US_CYC);
         2'h1:    filt_len = FILT_W'(FILT_2US_CYC);
         2'h2:    filt_len = FILT_W'(FILT_4US_CYC);
         default: filt_len = FILT_W'(FILT_8US_CYC);
      endcase
   endfunction

   // ---------------------------------------------------------------
   // configuration decode
   // ---------------------------------------------------------------
   logic              uv_en;
   logic              uv_now;
   logic              gde_en;
   logic              pcr_en;
   logic              link;
   logic [1:0]        vds_mode;
   logic [1:0]        sh_mode;
   logic [FILT_W-1:0] lim;
   logic              bus_req;
   logic              clr;
   logic [8:0]        raw;
   logic [8:0]        evt;
   logic [5:0]        vds_evt;
   logic [2:0]        sh_evt;
   logic              expire;
   logic              oc_gone;

   // undervoltage protection only switchable on serial parts
   assign uv_en  = !serial_variant_i || !r.ctrl[CTL_UV_DIS];
   // either gate rail low counts as undervoltage
   assign uv_now = uv_en && (charge_pump_rail_uv_i || low_side_gate_rail_uv_i);
   // gate fault detection switchable on serial parts
   assign gde_en = !serial_variant_i || !r.ctrl[CTL_GDE_DIS];
   // per-cycle recovery is on unless software turns it off
   assign pcr_en = !serial_variant_i || !r.ctrl[CTL_PCR_DIS];
   assign link   = serial_variant_i && r.ctrl[CTL_LINK];

   // pin parts retry, or stay off when the pin is tied high
   // serial parts take the mode field
   assign vds_mode = serial_variant_i ? r.ctrl[CTL_MODE_LO +: 2] :
                     (vds_pin_disable_i ? MODE_OFF : MODE_RETRY);
   // pin parts retry on shunt trips
   // shunt disable forces the shunt path off only
   assign sh_mode  = !serial_variant_i ? MODE_RETRY :
                     (r.ctrl[CTL_SH_DIS] ? MODE_OFF : r.ctrl[CTL_MODE_LO +: 2]);
   assign lim = serial_variant_i ? filt_len(r.ctrl[CTL_FILT_LO +: 2]) :
                FILT_W'(FILT_4US_CYC);

   // only fets being driven are watched for drain-source trips
   assign raw = {shunt_sense_input_over_i, drain_source_over_i & r.gate};
   assign oc_gone = (raw == 9'h000);

   // a trip is recognised once its counter reached the filter time
   // the shunt inputs use the same filter
   genvar gi;
   generate
      for (gi = 0; gi < 9; gi++) begin : g_filt
         assign evt[gi] = raw[gi] && (r.filt_cnt[gi] >= lim);
      end
   endgenerate

   // disabled mode masks drain-source events entirely
   assign vds_evt = (vds_mode == MODE_OFF) ? 6'h00 : evt[5:0];
   // shunt events masked in mode 11b or with shunt disable
   assign sh_evt  = (sh_mode == MODE_OFF) ? 3'h0 : evt[8:6];

   assign bus_req = wb_cyc_i && wb_stb_i && !r.ack;
   assign clr     = enable_reset_i ||
                    (bus_req && wb_we_i && (wb_adr_i == ADDR_CMD) &&
                     wb_sel_i[0] && wb_dat_i[CMD_CLR]);
   assign expire  = r.retry_act &&
                    (r.retry_cnt == RETRY_W'(RETRY_CYCLES - 1));

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [2:0]  shut_hit;
      logic [2:0]  ph_rise;
      logic [2:0]  ph_off;
      logic [5:0]  rise;
      logic        rep_hit;
      logic        retry_hit;
      logic        vds_any;
      logic        sh_any;
      logic        oc_clr;
      logic [31:0] rd;
      shut_hit  = 3'h0;
      ph_rise   = 3'h0;
      ph_off    = 3'h0;
      rise      = pwm_i & ~r.pwm_prev;
      vds_any   = |vds_evt;
      sh_any    = |sh_evt;
      rd        = 32'h0000_0000;
      rep_hit   = 1'b0;
      retry_hit = 1'b0;
      oc_clr    = 1'b0;
      n         = r;

      // filter counters saturate at the limit, drop at once on release
      for (int i = 0; i < 9; i++) begin
         if (!raw[i]) begin
            n.filt_cnt[i] = '0;
         end else if (r.filt_cnt[i] < lim) begin
            n.filt_cnt[i] = r.filt_cnt[i] + FILT_W'(1);
         end
      end

      for (int k = 0; k < 3; k++) begin
         shut_hit[k] = (((vds_evt[2*k] || vds_evt[2*k+1]) &&
                         (vds_mode == MODE_LATCH || vds_mode == MODE_RETRY)) ||
                        (sh_evt[k] &&
                         (sh_mode == MODE_LATCH || sh_mode == MODE_RETRY)));
         ph_rise[k]  = rise[2*k] || rise[2*k+1];
      end
      rep_hit   = (vds_any && vds_mode == MODE_REPORT) ||
                  (sh_any && sh_mode == MODE_REPORT);
      retry_hit = (vds_any && vds_mode == MODE_RETRY) ||
                  (sh_any && sh_mode == MODE_RETRY);
      // latched faults clear only once the trip has gone away
      oc_clr    = clr && oc_gone;

      // retry timer; events during the interval are absorbed
      if (r.retry_act) begin
         n.retry_cnt = r.retry_cnt + RETRY_W'(1);
         if (expire) begin
            n.retry_act = 1'b0;
            n.retry_cnt = '0;
         end
      end else if (retry_hit) begin
         n.retry_act = 1'b1;
         n.retry_cnt = '0;
      end

      // pwm edges, retry expiry or a clear drop pending shutdowns
      for (int k = 0; k < 3; k++) begin
         if ((pcr_en && ph_rise[k]) || expire || oc_clr) begin
            n.oc_pend[k] = 1'b0;
         end
         if (shut_hit[k]) begin
            n.oc_pend[k] = 1'b1;
         end
      end
      // report held until clear with the trip gone, or a pwm rising edge while per-cycle recovery is on
      if (oc_clr || (pcr_en && |ph_rise)) begin
         n.rep_pend = 1'b0;
      end
      if (rep_hit) begin
         n.rep_pend = 1'b1;
      end

      // overcurrent flags: clear first so that a new event wins
      if (expire || oc_clr) begin
         n.vds_flag = 1'b0;
         n.vds_fet  = 6'h00;
         n.sh_flag  = 1'b0;
         n.sh_phase = 3'h0;
      end
      // drain-source trips latch the summary and per-fet flags
      n.vds_flag = n.vds_flag || vds_any;
      n.vds_fet  = n.vds_fet | vds_evt;
      // per-phase shunt flags only in retry mode
      n.sh_flag  = n.sh_flag || sh_any;
      if (sh_mode == MODE_RETRY) begin
         n.sh_phase = n.sh_phase | sh_evt;
      end

      // undervoltage flag sticky until clear; set wins
      if (clr) begin
         n.uv_flag = 1'b0;
      end
      n.uv_flag = n.uv_flag || uv_now;

      // gate fault leaves only on clear with the gates moving
      if (clr && (gate_stuck_i == 6'h00)) begin
         n.gde_pend = 1'b0;
         n.gde_flag = 1'b0;
         n.gde_gate = 6'h00;
      end
      // a stuck gate latches fault and per-gate flags
      if (gde_en && (gate_stuck_i != 6'h00)) begin
         n.gde_pend = 1'b1;
         n.gde_flag = 1'b1;
         n.gde_gate = n.gde_gate | gate_stuck_i;
      end

      // linked mode spreads any pending shutdown to all phases
      for (int k = 0; k < 3; k++) begin
         ph_off[k] = uv_now || r.gde_pend ||
                     (link ? (|r.oc_pend) : r.oc_pend[k]);
      end
      // fets follow pwm only while their half-bridge is allowed
      for (int i = 0; i < 6; i++) begin
         n.gate[i] = pwm_i[i] && !ph_off[i/2];
      end
      n.pwm_prev = pwm_i;
      // pin low while any reporting source is active
      n.pin_n = !(uv_now || r.gde_pend || (|r.oc_pend) || r.rep_pend ||
                  r.retry_act);

      // wishbone: ack one cycle after the request, then drop
      n.ack = bus_req;
      case (wb_adr_i)
         ADDR_CTRL: rd[15:0] = r.ctrl;
         ADDR_STATUS: begin
            rd[ST_SUM]               = r.uv_flag || r.vds_flag ||
                                       r.sh_flag || r.gde_flag;
            rd[ST_UV]                = r.uv_flag;
            rd[ST_VDS]               = r.vds_flag;
            rd[ST_SH]                = r.sh_flag;
            rd[ST_GDE]               = r.gde_flag;
            rd[ST_VFET_LO +: 6]      = r.vds_fet;
            rd[ST_SPH_LO +: 3]       = r.sh_phase;
            rd[ST_GGATE_LO +: 6]     = r.gde_gate;
            rd[ST_PIN]               = !r.pin_n;
            rd[ST_RETRY]             = r.retry_act;
         end
         default: rd = 32'h0000_0000;
      endcase
      n.dat = bus_req ? rd : 32'h0000_0000;
      // control fields written byte by byte
      if (bus_req && wb_we_i && (wb_adr_i == ADDR_CTRL)) begin
         if (wb_sel_i[0]) begin
            n.ctrl[7:0] = wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            n.ctrl[15:8] = wb_dat_i[15:8];
         end
      end
      n.slvl = serial_variant_i ? n.ctrl[CTL_SLVL_LO +: 2] : SH_LVL_FIXED;
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r       <= '0;
         r.ctrl  <= CTRL_RST;
         r.pin_n <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // outputs straight from flops
   assign wb_ack_o                  = r.ack;
   assign wb_dat_o                  = r.dat;
   assign gate_drive_o              = r.gate;
   assign error_indicator_pin_n_o   = r.pin_n;
   assign drain_source_trip_level_o = r.ctrl[CTL_VLVL_LO +: 4];
   assign shunt_trip_level_o        = r.slvl;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_uv_gates_off: assert property (
      @(posedge clk_i) disable iff (rst_i)
      uv_now |=> (gate_drive_o == 6'h00) && !error_indicator_pin_n_o)
      else $error("gates or pin active during undervoltage");

   chk_uv_flag_set: assert property (
      @(posedge clk_i) disable iff (rst_i)
      uv_now |=> r.uv_flag)
      else $error("undervoltage flag not latched");

   chk_uv_flag_hold: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (r.uv_flag && !clr) |=> r.uv_flag)
      else $error("undervoltage flag lost without clear");

   chk_uv_pin_only: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (!serial_variant_i && charge_pump_rail_uv_i) |=> !(|gate_drive_o))
      else $error("undervoltage protection off on pin variant");

   chk_filter_wait: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $rose(raw[0]) |-> (!evt[0]) [*8])
      else $error("drain-source trip recognised before filter time");

   chk_link_all_off: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (link && (|r.oc_pend)) |=> (gate_drive_o == 6'h00))
      else $error("linked shutdown left a fet driven");

   chk_retry_release: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (expire && (evt == 9'h000)) |=>
         !r.retry_act && (r.oc_pend == 3'h0) && !r.vds_flag)
      else $error("retry expiry did not release the fault");

   chk_report_drives: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (r.rep_pend && (r.oc_pend == 3'h0) && !r.gde_pend && !uv_now)
         |=> (gate_drive_o == $past(pwm_i)) && !error_indicator_pin_n_o)
      else $error("report mode stopped the gates or freed the pin");

   chk_gde_latched: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (r.gde_pend && (gate_stuck_i != 6'h00)) |=> r.gde_pend)
      else $error("gate fault released while still stuck");

endmodule

// file: common/gdfp_pkg.sv
// Purpose: shared constants for the gate driver fault protection block
// Assumes: 40 MHz core clock, classic Wishbone register access
// Notes:   register image offsets are byte addresses, one word each
package gdfp_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_FREQ_KHZ  = 40000;
   localparam int FILT_1US_NS   = 1000;
   localparam int FILT_2US_NS   = 2000;
   localparam int FILT_4US_NS   = 4000;
   localparam int FILT_8US_NS   = 8000;
   localparam int RETRY_MS      = 8;
   // least times, rounded up to whole cycles
   localparam int FILT_1US_CYC  =
      (FILT_1US_NS * CLK_FREQ_KHZ + 999999) / 1000000;
   localparam int FILT_2US_CYC  =
      (FILT_2US_NS * CLK_FREQ_KHZ + 999999) / 1000000;
   localparam int FILT_4US_CYC  =
      (FILT_4US_NS * CLK_FREQ_KHZ + 999999) / 1000000;
   localparam int FILT_8US_CYC  =
      (FILT_8US_NS * CLK_FREQ_KHZ + 999999) / 1000000;
   localparam int RETRY_CYC     = RETRY_MS * CLK_FREQ_KHZ;
   localparam int FILT_W        = 9;
   localparam int RETRY_W       = 19;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CMD    = 8'h08;

   // ---------------------------------------------------------------
   // control word fields
   // ---------------------------------------------------------------
   localparam int CTL_UV_DIS    = 0;
   localparam int CTL_SH_DIS    = 1;
   localparam int CTL_GDE_DIS   = 2;
   localparam int CTL_PCR_DIS   = 3;
   localparam int CTL_LINK      = 4;
   localparam int CTL_MODE_LO   = 5;
   localparam int CTL_FILT_LO   = 7;
   localparam int CTL_VLVL_LO   = 9;
   localparam int CTL_SLVL_LO   = 13;
   localparam logic [15:0] CTRL_RST = 16'h0100;
   localparam int CMD_CLR       = 0;
   localparam logic [1:0] SH_LVL_FIXED = 2'h3;

   // ---------------------------------------------------------------
   // status word fields
   // ---------------------------------------------------------------
   localparam int ST_SUM        = 0;
   localparam int ST_UV         = 1;
   localparam int ST_VDS        = 2;
   localparam int ST_SH         = 3;
   localparam int ST_GDE        = 4;
   localparam int ST_VFET_LO    = 5;
   localparam int ST_SPH_LO     = 11;
   localparam int ST_GGATE_LO   = 14;
   localparam int ST_PIN        = 20;
   localparam int ST_RETRY      = 21;

   // overcurrent response modes
   localparam logic [1:0] MODE_LATCH  = 2'h0;
   localparam logic [1:0] MODE_RETRY  = 2'h1;
   localparam logic [1:0] MODE_REPORT = 2'h2;
   localparam logic [1:0] MODE_OFF    = 2'h3;

endpackage

// file: dv/gdfp_ctl_model.sv
// Purpose: motor controller model, drives pwm and watches error pin
// Assumes: all six pwm lines run high while the bridge is in use
// Notes:   restart_i gives one low cycle, hence a fresh rising edge
`timescale 1ns/10ps
module gdfp_ctl_model (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // bench control and pin watch
   input  wire logic       restart_i,
   input  wire logic       err_pin_n_i,
   // towards the block and the bench
   output logic      [5:0] pwm_o,
   output logic            fault_seen_o
);
   // ---------------------------------------------------------------
   // pwm source
   // ---------------------------------------------------------------
   // fresh pwm edge
   // low for one cycle only, so recovery tests see one clean edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwm_o        <= 6'h00;
         fault_seen_o <= 1'b0;
      end else begin
         pwm_o        <= restart_i ? 6'h00 : 6'h3f;
         fault_seen_o <= (fault_seen_o & ~restart_i) | ~err_pin_n_i;
      end
   end
endmodule

// file: dv/tb_top.sv
// Purpose: self-checking bench for the fault protection block
// Assumes: retry shortened to 50 cycles, filter select 0 is 40 cycles
// Notes:   ack and read data are taken at one rising edge, then released
`timescale 1ns/10ps
module tb_top;
   import gdfp_pkg::*;
   typedef struct packed {
      logic [15:0] ctl;
      logic        cp;
      logic        ls;
      logic [5:0]  stk;
      logic [5:0]  gd;
      logic        pin;
      logic        hold;
      logic [31:0] st;
   } gdfp_row_t;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic        ser = 1'b1, vpd = 1'b0, enr = 1'b0, rs = 1'b0;
   logic        cp = 1'b0, ls = 1'b0, pin_n, seen;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat = 32'h0, dat_o, q;
   logic [5:0]  ds = 6'h00, stk = 6'h00, pwm, gd;
   logic [3:0]  vlvl;
   logic [1:0]  slvl;
   logic [2:0]  sh = 3'h0;
   int          miscompares = 0;
   int          checks_done = 0;
   gdfp_row_t   rows [5];

   // 40 mhz clock
   always #12.5 clk_i = ~clk_i;

   gdfp_top #(.RETRY_CYCLES(50)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .serial_variant_i(ser),
      .vds_pin_disable_i(vpd), .enable_reset_i(enr),
      .charge_pump_rail_uv_i(cp), .low_side_gate_rail_uv_i(ls),
      .drain_source_over_i(ds), .shunt_sense_input_over_i(sh),
      .gate_stuck_i(stk), .pwm_i(pwm), .gate_drive_o(gd),
      .drain_source_trip_level_o(vlvl), .shunt_trip_level_o(slvl),
      .error_indicator_pin_n_o(pin_n));

   gdfp_ctl_model ctl (.clk_i(clk_i), .rst_i(rst_i), .restart_i(rs),
      .err_pin_n_i(pin_n), .pwm_o(pwm), .fault_seen_o(seen));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("Error %0t: got %h, want %h", $time, g, e);
      end
   endtask

   // one classic cycle; ack and data taken at one rising edge,
   // only the watchdog ends a wait that never sees ack
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   // settle a little after the edge so outputs are read stable
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic trip(input logic [15:0] c, input logic [5:0] d,
                       input logic [2:0] s, input int n);
      wb(1'b1, ADDR_CTRL, {16'h0, c});
      ds <= d;
      sh <= s;
      tick(n);
   endtask

   task automatic clr();
      ds <= 6'h00;
      sh <= 3'h0;
      wb(1'b1, ADDR_CMD, 32'h1);
      tick(3);
   endtask

   task automatic pulse();
      rs <= 1'b1;
      tick(1);
      rs <= 1'b0;
      tick(4);
   endtask

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // hang guard, far beyond the roughly 1200 cycles needed
   initial begin
      #(25 * 20000);
      miscompares++;
      give_verdict();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rows = '{
         '{16'h0100, 1'b1, 1'b0, 6'h00, 6'h00, 1'b0, 1'b1, 32'h00100003},
         '{16'h0100, 1'b0, 1'b1, 6'h00, 6'h00, 1'b0, 1'b1, 32'h00100003},
         '{16'h0101, 1'b1, 1'b0, 6'h00, 6'h3f, 1'b1, 1'b1, 32'h00000000},
         '{16'h0100, 1'b0, 1'b0, 6'h04, 6'h00, 1'b0, 1'b0, 32'h00110011},
         '{16'h0104, 1'b0, 1'b0, 6'h04, 6'h3f, 1'b1, 1'b1, 32'h00000000}};
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, ADDR_CTRL, 32'h0);
      chk(q, {16'h0, CTRL_RST});
      wb(1'b0, 8'h0c, 32'h0);
      chk(q, 32'h0);
      chk(32'(pin_n), 32'h1);
      wb(1'b1, ADDR_CTRL, 32'h5a00);
      tick(2);
      chk(32'(vlvl), 32'hd);
      chk(32'(slvl), 32'h2);
      $display("reset and levels done");
      foreach (rows[i]) begin
         wb(1'b1, ADDR_CTRL, {16'h0, rows[i].ctl});
         cp  <= rows[i].cp;
         ls  <= rows[i].ls;
         stk <= rows[i].stk;
         tick(3);
         chk(32'(gd), 32'(rows[i].gd));
         chk(32'(pin_n), 32'(rows[i].pin));
         wb(1'b0, ADDR_STATUS, 32'h0);
         chk(q, rows[i].st);
         cp  <= 1'b0;
         ls  <= 1'b0;
         stk <= 6'h00;
         tick(3);
         chk(32'(pin_n), 32'(rows[i].hold));
         wb(1'b0, ADDR_STATUS, 32'h0);
         chk(q & 32'h13, rows[i].st & 32'h13);
         clr();
         chk(32'(pin_n), 32'h1);
         wb(1'b0, ADDR_STATUS, 32'h0);
         chk(q, 32'h0);
         $display("row %0d done", i);
      end
      // latched mode, filter boundary, own half-bridge, pwm recovery
      trip(16'h0000, 6'h01, 3'h0, 38);
      chk(32'(gd), 32'h3f);
      tick(7);
      chk(32'(gd), 32'h3c);
      chk(32'(pin_n), 32'h0);
      ds <= 6'h00;
      tick(3);
      chk(32'(pin_n), 32'h0);
      pulse();
      chk(32'(gd), 32'h3f);
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk(q, 32'h25);
      clr();
      // recovery by pwm edge switched off, enable reset clears
      trip(16'h0008, 6'h01, 3'h0, 45);
      ds <= 6'h00;
      pulse();
      chk(32'(gd), 32'h3c);
      enr <= 1'b1;
      tick(1);
      enr <= 1'b0;
      tick(3);
      chk(32'(gd), 32'h3f);
      chk(32'(pin_n), 32'h1);
      $display("latched done");
      trip(16'h0010, 6'h04, 3'h0, 45);
      chk(32'(gd), 32'h00);
      clr();
      pulse();
      trip(16'h0020, 6'h01, 3'h0, 45);
      ds <= 6'h00;
      tick(20);
      chk(32'(gd), 32'h3c);
      tick(40);
      chk(32'(gd), 32'h3f);
      chk(32'(pin_n), 32'h1);
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk(q, 32'h0);
      $display("link and retry done");
      pulse();
      trip(16'h0040, 6'h01, 3'h0, 45);
      chk(32'(gd), 32'h3f);
      ds <= 6'h00;
      tick(3);
      chk(32'(pin_n), 32'h0);
      chk(32'(seen), 32'h1);
      clr();
      chk(32'(pin_n), 32'h1);
      trip(16'h0060, 6'h3f, 3'h7, 45);
      chk(32'(gd), 32'h3f);
      chk(32'(pin_n), 32'h1);
      clr();
      $display("report and off done");
      trip(16'h0020, 6'h00, 3'h2, 45);
      chk(32'(gd), 32'h33);
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk(q, 32'h00301009);
      sh <= 3'h0;
      tick(60);
      chk(32'(gd), 32'h3f);
      trip(16'h0002, 6'h00, 3'h1, 45);
      chk(32'(gd), 32'h3f);
      ds <= 6'h01;
      tick(45);
      chk(32'(gd), 32'h3c);
      clr();
      pulse();
      $display("shunt done");
      // pin configured part: fixed filter, fixed shunt level, strap
      wb(1'b1, ADDR_CTRL, 32'h0101);
      ser <= 1'b0;
      cp  <= 1'b1;
      tick(3);
      chk(32'(gd), 32'h00);
      chk(32'(slvl), 32'h3);
      cp  <= 1'b0;
      vpd <= 1'b1;
      ds  <= 6'h01;
      tick(170);
      chk(32'(gd), 32'h3f);
      // fresh trip after the strap is released; filter restarts at zero
      vpd <= 1'b0;
      ds  <= 6'h00;
      tick(1);
      ds  <= 6'h01;
      tick(150);
      chk(32'(gd), 32'h3f);
      tick(20);
      chk(32'(gd), 32'h3c);
      ds <= 6'h00;
      tick(70);
      chk(32'(gd), 32'h3f);
      $display("pin part done");
      give_verdict();
   end
endmodule
